// ### hw/scg_top.sv
`include "scg_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module scg_top (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [11:0] s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [11:0] s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    // System power mode
    input  wire logic [1:0]  power_mode,
    // Unit access probes from the system bus
    input  wire logic        can_access,
    input  wire logic        wdt_access,
    // Gated clock enables and faults
    output logic             can_clk_en,
    output logic             wdt_clk_en,
    output logic             can_bus_fault,
    output logic             wdt_bus_fault,
    // Interrupt
    output logic             irq
);
    scg_pkg::scg_state_t s_r;
    scg_pkg::scg_state_t s_nxt;
    logic [31:0] active;
    logic [31:0] wmask;
    logic [31:0] rd_val;
    logic        rd_hit;
    logic        do_write;
    logic [1:0]  events;

    // Sleep registers only steer clocks once sleep gating is selected
    always_comb begin
        active = s_r.run_r;
        if (s_r.select_r) begin
            unique case (power_mode)
                scg_pkg::SCG_MODE_SLEEP: active = s_r.sleep_r;
                scg_pkg::SCG_MODE_DEEP:  active = s_r.deep_r;
                default:                 active = s_r.run_r;
            endcase
        end
    end

    assign can_clk_en    = active[`SCG_BIT_CAN];
    assign wdt_clk_en    = active[`SCG_BIT_WDT];
    assign can_bus_fault = s_r.can_fault_r;
    assign wdt_bus_fault = s_r.wdt_fault_r;
    assign events        = {wdt_access & ~active[`SCG_BIT_WDT],
                            can_access & ~active[`SCG_BIT_CAN]};

    assign wmask = {{8{s_r.wstrb_r[3]}}, {8{s_r.wstrb_r[2]}},
                    {8{s_r.wstrb_r[1]}}, {8{s_r.wstrb_r[0]}}};
    assign do_write = s_r.aw_ok_r & s_r.w_ok_r & ~s_r.bvalid_r;

    always_comb begin
        rd_hit = 1'b1;
        unique case (s_araddr)
            `SCG_OFF_RUN:    rd_val = s_r.run_r;
            `SCG_OFF_SLEEP:  rd_val = s_r.sleep_r;
            `SCG_OFF_DEEP:   rd_val = s_r.deep_r;
            `SCG_OFF_CONFIG: rd_val = {31'h0, s_r.select_r};
            `SCG_OFF_ISTAT:  rd_val = {30'h0, s_r.istat_r};
            `SCG_OFF_IEN:    rd_val = {30'h0, s_r.ien_r};
            default: begin
                rd_val = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
    end

    assign s_awready = ~s_r.aw_ok_r & ~s_r.bvalid_r;
    assign s_wready  = ~s_r.w_ok_r & ~s_r.bvalid_r;
    assign s_arready = ~s_r.rvalid_r;
    assign s_bvalid  = s_r.bvalid_r;
    assign s_bresp   = s_r.bresp_r;
    assign s_rvalid  = s_r.rvalid_r;
    assign s_rdata   = s_r.rdata_r;
    assign s_rresp   = s_r.rresp_r;
    assign irq       = |(s_r.istat_r & s_r.ien_r);

    function automatic logic [31:0] gate_upd(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [31:0] m);
        logic [31:0] msk;
        msk = m & `SCG_RW_MASK;
        // Reserved bits stay fixed whatever is written
        gate_upd = ((old & ~msk) | (wd & msk)) | `SCG_FIXED_ONES;
    endfunction : gate_upd

    always_comb begin
        s_nxt = s_r;
        s_nxt.can_fault_r = events[`SCG_EV_CAN_FAULT];
        s_nxt.wdt_fault_r = events[`SCG_EV_WDT_FAULT];
        if (s_awvalid && s_awready) begin
            s_nxt.aw_ok_r  = 1'b1;
            s_nxt.awaddr_r = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            s_nxt.w_ok_r  = 1'b1;
            s_nxt.wdata_r = s_wdata;
            s_nxt.wstrb_r = s_wstrb;
        end
        if (do_write) begin
            s_nxt.aw_ok_r  = 1'b0;
            s_nxt.w_ok_r   = 1'b0;
            s_nxt.bvalid_r = 1'b1;
            s_nxt.bresp_r  = `SCG_RESP_OKAY;
            unique case (s_r.awaddr_r)
                `SCG_OFF_RUN: s_nxt.run_r =
                    gate_upd(s_r.run_r, s_r.wdata_r, wmask);
                `SCG_OFF_SLEEP: s_nxt.sleep_r =
                    gate_upd(s_r.sleep_r, s_r.wdata_r, wmask);
                `SCG_OFF_DEEP: s_nxt.deep_r =
                    gate_upd(s_r.deep_r, s_r.wdata_r, wmask);
                `SCG_OFF_CONFIG:
                    if (s_r.wstrb_r[0])
                        s_nxt.select_r = s_r.wdata_r[`SCG_BIT_SELECT];
                `SCG_OFF_ISTAT: ;
                `SCG_OFF_IEN:
                    if (s_r.wstrb_r[0])
                        s_nxt.ien_r = s_r.wdata_r[1:0];
                `SCG_OFF_ICLR:
                    if (s_r.wstrb_r[0])
                        s_nxt.istat_r = s_r.istat_r & ~s_r.wdata_r[1:0];
                default: s_nxt.bresp_r = `SCG_RESP_SLVERR;
            endcase
        end
        // Set wins over a clear in the same cycle
        s_nxt.istat_r = s_nxt.istat_r | events;
        if (s_r.bvalid_r && s_bready)
            s_nxt.bvalid_r = 1'b0;
        if (s_r.rvalid_r && s_rready)
            s_nxt.rvalid_r = 1'b0;
        if (s_arvalid && s_arready) begin
            s_nxt.rvalid_r = 1'b1;
            s_nxt.rdata_r  = rd_val;
            s_nxt.rresp_r  = rd_hit ? `SCG_RESP_OKAY : `SCG_RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r         <= '0;
            s_r.run_r   <= `SCG_RESET_VAL;
            s_r.sleep_r <= `SCG_RESET_VAL;
            s_r.deep_r  <= `SCG_RESET_VAL;
        end else begin
            s_r <= s_nxt;
        end
    end

    chk_fault_when_gated: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (can_access && !can_clk_en) |=> can_bus_fault)
        else $error("gated network unit access without fault");

    chk_no_fault_clocked: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (wdt_access && wdt_clk_en) |=> !wdt_bus_fault)
        else $error("clocked watchdog access faulted");

    chk_bit6_fixed: assert property (@(posedge aclk)
        disable iff (!aresetn)
        s_r.sleep_r[6] && ((s_r.sleep_r & ~`SCG_RW_MASK) == `SCG_FIXED_ONES))
        else $error("sleep register reserved bits changed");

    chk_sleep_select: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (!s_r.select_r) |-> (can_clk_en == s_r.run_r[`SCG_BIT_CAN]))
        else $error("sleep gating used without select");

    chk_sleep_applies: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (s_r.select_r && power_mode == scg_pkg::SCG_MODE_SLEEP)
        |-> (wdt_clk_en == s_r.sleep_r[`SCG_BIT_WDT]))
        else $error("sleep gating not applied");

    chk_reset_clear: assert property (@(posedge aclk)
        $rose(aresetn) |-> (s_r.sleep_r == `SCG_RESET_VAL))
        else $error("sleep register reset value wrong");

    chk_write_lands: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (do_write && s_r.awaddr_r == `SCG_OFF_SLEEP && s_r.wstrb_r[3])
        |=> (s_r.sleep_r[`SCG_BIT_CAN] == $past(s_r.wdata_r[`SCG_BIT_CAN])))
        else $error("network gate bit write lost");

    chk_wdt_write: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (do_write && s_r.awaddr_r == `SCG_OFF_SLEEP && s_r.wstrb_r[0])
        |=> (s_r.sleep_r[`SCG_BIT_WDT] == $past(s_r.wdata_r[`SCG_BIT_WDT])))
        else $error("watchdog gate bit write lost");

    chk_reserved_ign: assert property (@(posedge aclk)
        disable iff (!aresetn)
        do_write |=> ((s_r.run_r & ~`SCG_RW_MASK) == `SCG_FIXED_ONES))
        else $error("reserved run bits took a write");
endmodule : scg_top
`default_nettype wire

// ### hw/scg_regs.svh
// Overview of operation
// - A set gating bit lets its unit receive a clock and run normally.
// - A cleared gating bit withholds the unit's clock to save power.
// - Any access to a unit whose clock is gated off answers a bus fault.
// - Gating bits come up cleared after reset unless noted otherwise.
// - Run, sleep and deep-sleep gating registers each exist separately.
// - Sleep and deep-sleep gating apply only with sleep gating selected.
// - Bit 24 is a read-write, reset-zero enable for network unit zero.
// - Bit 3 is a read-write, reset-zero enable for the watchdog clock.
// - The sleep register is 32 bits, resets to 0x40, bit 6 reads one.
`ifndef SCG_REGS_SVH
`define SCG_REGS_SVH
`define SCG_OFF_RUN      12'h100
`define SCG_OFF_SLEEP    12'h110
`define SCG_OFF_DEEP     12'h120
`define SCG_OFF_CONFIG   12'h060
`define SCG_OFF_ISTAT    12'h130
`define SCG_OFF_IEN      12'h134
`define SCG_OFF_ICLR     12'h138
`define SCG_BIT_CAN      24
`define SCG_BIT_WDT      3
`define SCG_BIT_SELECT   0
`define SCG_RW_MASK      32'h01000008
`define SCG_FIXED_ONES   32'h00000040
`define SCG_RESET_VAL    32'h00000040
`define SCG_RESP_OKAY    2'b00
`define SCG_RESP_SLVERR  2'b10
`define SCG_EV_CAN_FAULT 0
`define SCG_EV_WDT_FAULT 1
`define SCG_EV_WIDTH     2
`endif

// ### hw/scg_pkg.sv
package scg_pkg;
    typedef enum logic [1:0] {
        SCG_MODE_RUN   = 2'b00,
        SCG_MODE_SLEEP = 2'b01,
        SCG_MODE_DEEP  = 2'b10
    } scg_mode_t;

    typedef enum logic [2:0] {
        SCG_W_IDLE = 3'b001,
        SCG_W_RESP = 3'b010,
        SCG_W_HOLD = 3'b100
    } scg_wst_t;

    typedef struct packed {
        logic [31:0] run_r;
        logic [31:0] sleep_r;
        logic [31:0] deep_r;
        logic        select_r;
        logic [1:0]  istat_r;
        logic [1:0]  ien_r;
        logic        aw_ok_r;
        logic [11:0] awaddr_r;
        logic        w_ok_r;
        logic [31:0] wdata_r;
        logic [3:0]  wstrb_r;
        logic        bvalid_r;
        logic [1:0]  bresp_r;
        logic        rvalid_r;
        logic [31:0] rdata_r;
        logic [1:0]  rresp_r;
        logic        can_fault_r;
        logic        wdt_fault_r;
    } scg_state_t;
endpackage : scg_pkg

// ### test/scg_tb.sv
`include "scg_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
    // Clock, reset and register bus
    logic        aclk, aresetn;
    logic [11:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata;
    logic [3:0]  s_wstrb;
    logic [1:0]  s_bresp, s_rresp, power_mode;
    logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
    logic        s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
    // Unit probes, enables, faults
    logic        can_access, wdt_access, can_clk_en, wdt_clk_en;
    logic        can_bus_fault, wdt_bus_fault, irq;
    int          failures, samples_checked;

    scg_top dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
        .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready), .power_mode(power_mode),
        .can_access(can_access), .wdt_access(wdt_access),
        .can_clk_en(can_clk_en), .wdt_clk_en(wdt_clk_en),
        .can_bus_fault(can_bus_fault), .wdt_bus_fault(wdt_bus_fault),
        .irq(irq));

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic results();
        $display("checked %0d, failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic stop();
        failures++;
        $display("[ERR] %0t: handshake timeout", $time);
        results();
    endtask : stop

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata  <= d;
        s_wstrb  <= 4'hf;
        {s_awvalid, s_wvalid, s_bready} <= 3'b111;
        do begin
            @(posedge aclk);
            n++;
            if (s_awvalid && s_awready === 1'b1) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready === 1'b1) s_wvalid <= 1'b0;
        end while (s_bvalid !== 1'b1 && n < 50);
        s_bready <= 1'b0;
        if (n >= 50) stop();
        chk(s_bresp, er);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_araddr <= a;
        {s_arvalid, s_rready} <= 2'b11;
        do begin
            @(posedge aclk);
            n++;
            if (s_arvalid && s_arready === 1'b1) s_arvalid <= 1'b0;
        end while (s_rvalid !== 1'b1 && n < 50);
        s_rready <= 1'b0;
        if (n >= 50) stop();
        chk(s_rdata, ed);
        chk(s_rresp, er);
    endtask : rd

    task automatic gate(input logic [1:0] m, input logic [1:0] e);
        @(posedge aclk);
        power_mode <= m;
        @(posedge aclk);
        #1 chk({can_clk_en, wdt_clk_en}, e);
    endtask : gate

    // One-cycle access; fault expected the cycle after, then gone
    task automatic probe(input logic [1:0] acc, input logic [1:0] e);
        @(posedge aclk);
        {can_access, wdt_access} <= acc;
        @(posedge aclk);
        {can_access, wdt_access} <= 2'b00;
        #1 chk({can_bus_fault, wdt_bus_fault}, e);
        @(posedge aclk);
        #1 chk({can_bus_fault, wdt_bus_fault}, 2'b00);
    endtask : probe

    initial begin
        {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        {can_access, wdt_access, power_mode} = '0;
        {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
        failures = 0;
        samples_checked = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        chk({can_clk_en, wdt_clk_en}, 2'b00);
        rd(`SCG_OFF_RUN, `SCG_RESET_VAL, `SCG_RESP_OKAY);
        rd(`SCG_OFF_SLEEP, `SCG_RESET_VAL, `SCG_RESP_OKAY);
        rd(`SCG_OFF_DEEP, `SCG_RESET_VAL, `SCG_RESP_OKAY);
        wr(`SCG_OFF_SLEEP, 32'hffffffff, `SCG_RESP_OKAY);
        rd(`SCG_OFF_SLEEP, 32'h01000048, `SCG_RESP_OKAY);
        wr(`SCG_OFF_SLEEP, 32'h00000000, `SCG_RESP_OKAY);
        rd(`SCG_OFF_SLEEP, 32'h00000040, `SCG_RESP_OKAY);
        // Reserved bit 6 written back as read
        wr(`SCG_OFF_RUN, 32'h01000040, `SCG_RESP_OKAY);
        wr(`SCG_OFF_SLEEP, 32'h00000048, `SCG_RESP_OKAY);
        wr(`SCG_OFF_DEEP, 32'h01000048, `SCG_RESP_OKAY);
        gate(scg_pkg::SCG_MODE_RUN, 2'b10);
        gate(scg_pkg::SCG_MODE_SLEEP, 2'b10);
        wr(`SCG_OFF_CONFIG, 32'h00000001, `SCG_RESP_OKAY);
        gate(scg_pkg::SCG_MODE_SLEEP, 2'b01);
        gate(scg_pkg::SCG_MODE_DEEP, 2'b11);
        // Both units clocked: no access may fault
        probe(2'b11, 2'b00);
        gate(2'h3, 2'b10);
        wr(`SCG_OFF_IEN, 32'h00000003, `SCG_RESP_OKAY);
        rd(`SCG_OFF_IEN, 32'h00000003, `SCG_RESP_OKAY);
        probe(2'b10, 2'b00);
        probe(2'b01, 2'b01);
        chk(irq, 1'b1);
        rd(`SCG_OFF_ISTAT, 32'h00000002, `SCG_RESP_OKAY);
        wr(`SCG_OFF_ISTAT, 32'h00000000, `SCG_RESP_OKAY);
        rd(`SCG_OFF_ISTAT, 32'h00000002, `SCG_RESP_OKAY);
        wr(`SCG_OFF_ICLR, 32'h00000002, `SCG_RESP_OKAY);
        chk(irq, 1'b0);
        rd(`SCG_OFF_ISTAT, 32'h00000000, `SCG_RESP_OKAY);
        // Network unit clock pulled while in run mode
        wr(`SCG_OFF_RUN, 32'h00000040, `SCG_RESP_OKAY);
        gate(scg_pkg::SCG_MODE_RUN, 2'b00);
        probe(2'b10, 2'b10);
        rd(`SCG_OFF_ISTAT, 32'h00000001, `SCG_RESP_OKAY);
        chk(irq, 1'b1);
        wr(`SCG_OFF_IEN, 32'h00000000, `SCG_RESP_OKAY);
        chk(irq, 1'b0);
        rd(`SCG_OFF_ISTAT, 32'h00000001, `SCG_RESP_OKAY);
        wr(`SCG_OFF_ICLR, 32'h00000001, `SCG_RESP_OKAY);
        rd(`SCG_OFF_ISTAT, 32'h00000000, `SCG_RESP_OKAY);
        // Write-only clear and unmapped space both refuse
        rd(`SCG_OFF_ICLR, 32'h00000000, `SCG_RESP_SLVERR);
        wr(12'h200, 32'h00000001, `SCG_RESP_SLVERR);
        rd(12'h200, 32'h00000000, `SCG_RESP_SLVERR);
        results();
    end
endmodule : tb
`default_nettype wire
